/* File: logic/tps_defines.vh */
// Constants for the timer 1 and port-bit skip decoder.
// Assumes 10-bit instruction words and 4-bit working registers.
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH
`define TPS_OP_SKIP_W1      10'h024
`define TPS_OP_SKIP_W2      10'h02b
`define TPS_OP_LOAD_T1      10'h230
`define TPS_OP_LOAD_HI      10'h292
`define TPS_OP_COPY_LO      10'h2a7
`define TPS_PORT_BITS       6
`define TPS_SEL_MAX         4'h5
`define TPS_BYTE_RESET      8'h00
`define TPS_NIB_HI          7:4
`define TPS_NIB_LO          3:0
`endif

/* File: logic/tps_port_bit_sel.v */
// Port bit selector: picks one port bit by the index register.
// Assumes port and index are already in the sys_clk domain.
`timescale 1ns/10ps
`include "tps_defines.vh"
module tps_port_bit_sel (
	input  wire [`TPS_PORT_BITS-1:0] port_bits,
	input  wire [3:0]                bit_index,
	output reg                       bit_value
);
	always @* begin
		bit_value = 1'b0;
		if (bit_index <= `TPS_SEL_MAX) begin
			bit_value = port_bits[bit_index[2:0]];
		end
	end
endmodule

/* File: logic/tps_decoder.v */
// Decode and execute of port-bit skip and timer 1 load instructions.
// Assumes the sequencer presents one instruction word per cycle with instr_valid.
// Notes on behaviour
// - The port-bit skip tests the port bit chosen by the selector and skips the next instruction when it is zero.
// - The port-bit skip is the two-word pair 0x024 then 0x02b, takes two cycles and leaves carry alone.
// - Load timer 1 writes high operand to bits 7-4 and low source to bits 3-0 of timer 1 and low reload together.
// - Load timer 1 is the single-cycle opcode 0x230 with no carry change and no skip.
// - Load high reload, opcode 0x292, puts high operand in bits 7-4 and low source in bits 3-0 of high reload.
// - Copy low reload, opcode 0x2a7, moves all eight low reload bits into timer 1 with no flag or skip.
`timescale 1ns/10ps
`include "tps_defines.vh"
module tps_decoder (
	input  wire                      sys_clk,
	input  wire                      reset,
	input  wire                      instr_valid,
	input  wire [9:0]                instr_word,
	input  wire [3:0]                reg_high,
	input  wire [3:0]                reg_low,
	input  wire [3:0]                bit_index,
	input  wire [`TPS_PORT_BITS-1:0] port_pins,
	output reg                       skip_next,
	output reg                       skip_busy,
	output reg                       timer1_load,
	output reg  [7:0]                timer1_value,
	output reg  [7:0]                timer1_low_reload,
	output reg  [7:0]                timer1_high_reload
);
	reg  [`TPS_PORT_BITS-1:0] pin_meta_reg;
	reg  [`TPS_PORT_BITS-1:0] pin_sync_reg;
	reg                       first_word_reg;
	wire                      sel_bit;
	wire                      is_skip1;
	wire                      is_skip2;

	always @(posedge sys_clk) begin
		if (reset) begin
			pin_meta_reg <= {`TPS_PORT_BITS{1'b0}};
			pin_sync_reg <= {`TPS_PORT_BITS{1'b0}};
		end else begin
			pin_meta_reg <= port_pins;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	tps_port_bit_sel u_sel (
		.port_bits (pin_sync_reg),
		.bit_index (bit_index),
		.bit_value (sel_bit)
	);

	assign is_skip1 = instr_valid && (instr_word == `TPS_OP_SKIP_W1) && !first_word_reg;
	assign is_skip2 = instr_valid && (instr_word == `TPS_OP_SKIP_W2) && first_word_reg;

	always @(posedge sys_clk) begin
		if (reset) begin
			first_word_reg     <= 1'b0;
			skip_next          <= 1'b0;
			skip_busy          <= 1'b0;
			timer1_load        <= 1'b0;
			timer1_value       <= `TPS_BYTE_RESET;
			timer1_low_reload  <= `TPS_BYTE_RESET;
			timer1_high_reload <= `TPS_BYTE_RESET;
		end else begin
			skip_next   <= 1'b0;
			timer1_load <= 1'b0;
			skip_busy   <= 1'b0;
			if (instr_valid) begin
				first_word_reg <= 1'b0;
			end
			if (is_skip1) begin
				first_word_reg <= 1'b1;
				skip_busy      <= 1'b1;
			end else if (is_skip2) begin
				skip_next <= ~sel_bit;
			end else if (instr_valid && !first_word_reg) begin
				case (instr_word)
					`TPS_OP_LOAD_T1: begin
						timer1_value[`TPS_NIB_HI]      <= reg_high;
						timer1_value[`TPS_NIB_LO]      <= reg_low;
						timer1_low_reload[`TPS_NIB_HI] <= reg_high;
						timer1_low_reload[`TPS_NIB_LO] <= reg_low;
						timer1_load                    <= 1'b1;
					end
					`TPS_OP_LOAD_HI: begin
						timer1_high_reload[`TPS_NIB_HI] <= reg_high;
						timer1_high_reload[`TPS_NIB_LO] <= reg_low;
					end
					`TPS_OP_COPY_LO: begin
						timer1_value <= timer1_low_reload;
						timer1_load  <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

/* File: bench/tps_port_model.sv */
// Port pins model.
`timescale 1ns/10ps
module tps_port_model(input [5:0] pin_set,output [5:0] port_pins);
	assign port_pins=pin_set;
endmodule

/* File: bench/tps_chk.sv */
// Decoder checks.
`timescale 1ns/10ps
module tps_chk(input sys_clk,reset,instr_valid,skip_next,skip_busy,timer1_load,input [9:0] instr_word,
	input [3:0] reg_high,reg_low,input [7:0] timer1_value,timer1_low_reload,timer1_high_reload);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire v=instr_valid;
	wire [9:0] w=instr_word;
	wire [7:0] b={reg_high,reg_low};
	wire f=!skip_busy;
	t1_load_a: assert property(v&&f&&w==10'h230|=>timer1_value==$past(b)) else $error("timer load wrong");
	lo_reload_a: assert property(v&&f&&w==10'h230|=>timer1_low_reload==$past(b)) else $error("low reload wrong");
	load_pulse_a: assert property(v&&f&&(w==10'h230||w==10'h2a7)|=>timer1_load) else $error("no load pulse");
	hi_load_a: assert property(v&&f&&w==10'h292|=>timer1_high_reload==$past(b)) else $error("high reload wrong");
	copy_lo_a: assert property(v&&f&&w==10'h2a7|=>timer1_value==$past(timer1_low_reload)) else $error("copy wrong");
	no_skip_a: assert property(v&&w[9]|=>!skip_next) else $error("bad");
	skip_word_a: assert property(skip_next|->$past(w)==10'h02b) else $error("bad");
	busy_word_a: assert property(skip_busy|->$past(w)==10'h024) else $error("bad");
	cover property(skip_next); cover property(timer1_load); cover property(skip_busy);
endmodule
bind tps_decoder tps_chk c(.*);

/* File: bench/timer1_and_port_skip_instructions_test.sv */
// Decoder bench.
`timescale 1ns/10ps
module timer1_and_port_skip_instructions_test;
	logic sys_clk=0,reset=1,instr_valid=0,skip_next,skip_busy,timer1_load;
	logic [9:0] instr_word=0;
	logic [3:0] reg_high=0,reg_low=0,bit_index=0;
	logic [5:0] pin_set=0,port_pins;
	logic [7:0] timer1_value,timer1_low_reload,timer1_high_reload;
	int errors,cmp_count;
	tps_decoder dut_u(.*);
	tps_port_model pm_u(.*);
	initial forever #12.5 sys_clk=~sys_clk;
	task test_done; if (errors==0&&cmp_count>0) $display("Finished cleanly");
		else $display("Finished with errors"); $finish; endtask
	task chk(input [7:0] s,e); cmp_count++; if (s!==e) begin errors++;
		$display("CHECK FAILED %0t bad",$time); end endtask
	task op(input [9:0] x,input o); @(negedge sys_clk) {instr_valid,instr_word}={o,x}; endtask
	task t_timer; {reg_high,reg_low}=8'ha5; op(10'h230,1); op(10'h292,1); {reg_high,reg_low}=8'h3c;
		chk(timer1_value,8'ha5);
		chk(timer1_low_reload,8'ha5);
		chk({timer1_load,skip_next},2'b10);
		op(10'h2a7,1); chk(timer1_high_reload,8'h3c);
		chk(timer1_load,0);
		op(0,0); chk({timer1_load,timer1_value[6:0]},8'ha5); endtask
	task t_abort; pin_set=0; bit_index=0; repeat(3) @(negedge sys_clk); op(10'h024,1); op(10'h230,1);
		chk(skip_busy,1);
		op(10'h02b,1); op(0,0); chk(timer1_value,8'ha5);
		chk(skip_next,0);
	endtask
	task t_skip; for (int i=0;i<12;i++) begin
		bit_index=4'(i%6); pin_set=i<6?6'h15:6'h2a;
		repeat(3) @(negedge sys_clk); op(10'h024,1); op(10'h02b,1); chk(skip_busy,1);
		op(0,0); chk({skip_next,7'h0},{!pin_set[bit_index],7'h0});
	end endtask
	initial begin repeat(6) @(negedge sys_clk); reset=0; t_timer; t_skip; t_abort; test_done; end
	initial begin repeat(900) @(posedge sys_clk); errors++; test_done; end
endmodule
